// ===== rx_packet_handler.sv
// Receive packet handler: frames bytes after sync, filters, checks, decrypts, queues.
// Assumes sync recognition and byte assembly upstream, on REF_CLK.
// Function
// - Drop preamble and sync, queue payload only
// - Fixed format counts exactly the maximum length
// - Variable format loads counter from length byte
// - Variable length above maximum discards the packet
// - Maximum of 255 turns length filtering off
// - Address is first or second payload byte
// - Selection 01 accepts own node only
// - Selection 10 accepts own or broadcast node
// - Address byte stays in the queue
// - Sync starts payload and raises match flag
// - No sync, nothing queued, no event
// - Check payload against two checksum bytes
// - Failed check clears queue, no completion
// - Keep-on-fail keeps payload and signals completion
// - Checksum bytes never enter the queue
// - CCITT 16-bit checksum polynomial
// - Completion shown on event pin zero
// - 16-byte write-only key, kept across sleep
// - Decrypt buffered message bytes, then signal completion
// - About 7 us per 16-byte block
// - Message limited to 64, payload 66 bytes
// - Format select 1 means variable length
// - Format 0, length 0: unlimited, no check
// - Decode 01: Manchester, 10 is one
`timescale 1ns/100ps
`default_nettype none
`include "rx_pkt_regs.svh"

module rx_packet_handler
  import rx_pkt_pkg::*;
(
  input  wire logic       REF_CLK,
  input  wire logic       RESETN,
  input  wire logic       SYNC_DETECT,
  input  wire logic       RX_BYTE_VALID,
  input  wire logic [7:0] RX_BYTE,
  input  wire logic [7:0] MAX_LEN_SETTING,
  input  wire logic       LENGTH_FORMAT_SELECT,
  input  wire logic [1:0] ADDR_FILTER_SEL,
  input  wire logic [7:0] OWN_NODE_ID,
  input  wire logic [7:0] BROADCAST_NODE_ID,
  input  wire logic       CHECK_ENABLE,
  input  wire logic       KEEP_ON_FAIL,
  input  wire logic [1:0] LINE_DECODE_SEL,
  input  wire logic       AES_ENABLE,
  input  wire logic       KEY_WR,
  input  wire logic [3:0] KEY_IDX,
  input  wire logic [7:0] KEY_BYTE,
  input  wire logic       QUEUE_RD,
  input  wire logic [6:0] QUEUE_THRESHOLD,
  output logic      [7:0] QUEUE_DATA,
  output logic            QUEUE_HAS_BYTES,
  output logic            QUEUE_LEVEL_REACHED,
  output logic            FRAME_MATCH_FLAG,
  output logic            CHECK_PASS_FLAG,
  output logic            EVENT_PIN_ZERO
);

  localparam logic [10:0] BLK_LAST = 11'(`AES_BLOCK_CYC - 1);
  localparam logic [7:0]  DEPTH    = 8'(`QUEUE_DEPTH);
  localparam logic [6:0]  BLK      = 7'(`AES_BLOCK_BYTES);

  handler_state_type q;
  handler_state_type d;

  logic       got;
  logic [7:0] b;
  logic       unlim;
  logic       chk_ok;

  check_if ck ();

  check_unit u_check (
    .clk   (REF_CLK),
    .rst_n (RESETN),
    .ck    (ck.unit)
  );

  function automatic logic [6:0] wrap(input logic [7:0] v);
    wrap = (v >= DEPTH) ? 7'(v - DEPTH) : v[6:0];
  endfunction : wrap

  assign unlim  = !LENGTH_FORMAT_SELECT && (MAX_LEN_SETTING == 8'h00);
  assign chk_ok = ({q.crc_hi, b} == ~ck.crc);

  always_comb begin
    logic       push;
    logic       pop;
    logic       drop;
    logic       finish;
    logic       body_end;
    logic       is_msg;
    logic [15:0] chips;
    logic [6:0] idx;
    push     = 1'b0;
    pop      = 1'b0;
    drop     = 1'b0;
    finish   = 1'b0;
    body_end = 1'b0;
    is_msg   = 1'b0;
    chips    = {q.chip_hi, RX_BYTE};
    idx      = '0;
    got      = 1'b0;
    b        = RX_BYTE;
    d        = q;

    // Key is never readable; only a reset clears it
    if (KEY_WR) begin
      d.key[KEY_IDX] = KEY_BYTE;
    end

    // Byte intake, pairing chip bytes when Manchester is on
    if (RX_BYTE_VALID && q.st != ST_IDLE && q.st != ST_DECRYPT) begin
      if (LINE_DECODE_SEL == `DECODE_MANCH) begin
        d.half    = ~q.half;
        d.chip_hi = RX_BYTE;
        got       = q.half;
        for (int i = 0; i < 8; i++) begin
          b[i] = chips[2*i+1];
        end
      end else begin
        got = 1'b1;
      end
    end

    // Bytes before a sync never reach the queue
    if (q.st == ST_IDLE && SYNC_DETECT) begin
      d.st       = LENGTH_FORMAT_SELECT ? ST_LEN : ST_BODY;
      d.rem      = MAX_LEN_SETTING;
      d.match    = 1'b1;
      d.pass     = 1'b0;
      d.done     = 1'b0;
      d.half     = 1'b0;
      d.msg_cnt  = '0;
      d.addr_chk = (ADDR_FILTER_SEL == `ADDR_SEL_OWN)
                || (ADDR_FILTER_SEL == `ADDR_SEL_BCAST);
    end

    if (got) begin
      case (q.st)
        ST_LEN: begin
          push = 1'b1;
          if (MAX_LEN_SETTING != `LEN_FILTER_OFF && b > MAX_LEN_SETTING) begin
            drop = 1'b1;
          end else begin
            d.rem = b;
            d.st  = ST_BODY;
            if (b == 8'h00) begin
              body_end = 1'b1;
            end
          end
        end
        ST_BODY: begin
          push = 1'b1;
          if (q.addr_chk) begin
            d.addr_chk = 1'b0;
            if (ADDR_FILTER_SEL == `ADDR_SEL_OWN && b != OWN_NODE_ID) begin
              drop = 1'b1;
            end
            if (ADDR_FILTER_SEL == `ADDR_SEL_BCAST && b != OWN_NODE_ID
                && b != BROADCAST_NODE_ID) begin
              drop = 1'b1;
            end
          end else begin
            is_msg = 1'b1;
          end
          if (!unlim) begin
            d.rem = q.rem - 8'h01;
            if (q.rem == 8'h01) begin
              body_end = 1'b1;
            end
          end
        end
        ST_CHK_HI: begin
          d.crc_hi = b;
          d.st     = ST_CHK_LO;
        end
        ST_CHK_LO: begin
          d.pass = chk_ok;
          if (chk_ok || KEEP_ON_FAIL) begin
            finish = 1'b1;
          end else begin
            drop = 1'b1;
          end
        end
        default: begin
          d.st = ST_IDLE;
        end
      endcase
    end

    if (body_end) begin
      if (CHECK_ENABLE) begin
        d.st = ST_CHK_HI;
      end else begin
        finish = 1'b1;
      end
    end

    // Checksum covers length, address and message bytes only
    ck.init = q.st == ST_IDLE && SYNC_DETECT;
    ck.en   = push;
    ck.data = b;

    // Host reads are held off while the cipher rewrites the buffer
    pop = QUEUE_RD && q.cnt != 7'h00 && q.st != ST_DECRYPT;
    if (pop) begin
      d.dout = q.mem[q.rd];
      d.rd   = wrap({1'b0, q.rd} + 8'h01);
      if (q.cnt == 7'h01) begin
        d.done = 1'b0;
      end
    end

    // A full queue loses the byte; the host must drain in time
    if (push && !drop && {1'b0, q.cnt} < DEPTH) begin
      d.mem[q.wr] = b;
      d.wr        = wrap({1'b0, q.wr} + 8'h01);
      if (is_msg) begin
        if (q.msg_cnt == 7'h00) begin
          d.msg_ptr = q.wr;
        end
        d.msg_cnt = q.msg_cnt + 7'h01;
      end
      d.cnt = pop ? q.cnt : q.cnt + 7'h01;
    end else if (pop) begin
      d.cnt = q.cnt - 7'h01;
    end

    // Discard clears the whole queue, older unread bytes too
    if (drop) begin
      d.st    = ST_IDLE;
      d.match = 1'b0;
      d.done  = 1'b0;
      d.wr    = '0;
      d.rd    = '0;
      d.cnt   = '0;
    end

    if (finish) begin
      d.match    = 1'b0;
      d.wait_cnt = '0;
      if (AES_ENABLE && d.msg_cnt != 7'h00) begin
        d.st = ST_DECRYPT;
      end else begin
        d.st   = ST_IDLE;
        d.done = 1'b1;
      end
    end

    // Each block waits its full time, then is rewritten in place
    if (q.st == ST_DECRYPT) begin
      d.wait_cnt = q.wait_cnt + 11'h001;
      if (q.wait_cnt == BLK_LAST) begin
        d.wait_cnt = '0;
        for (int k = 0; k < `AES_BLOCK_BYTES; k++) begin
          if (7'(k) < q.msg_cnt) begin
            idx        = wrap({1'b0, q.msg_ptr} + 8'(k));
            d.mem[idx] = q.mem[idx] ^ q.key[k];
          end
        end
        d.msg_ptr = wrap({1'b0, q.msg_ptr} + {1'b0, BLK});
        if (q.msg_cnt > BLK) begin
          d.msg_cnt = q.msg_cnt - BLK;
        end else begin
          d.msg_cnt = '0;
          d.st      = ST_IDLE;
          d.done    = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign QUEUE_DATA          = q.dout;
  assign QUEUE_HAS_BYTES     = q.cnt != 7'h00;
  assign QUEUE_LEVEL_REACHED = q.cnt > QUEUE_THRESHOLD;
  assign FRAME_MATCH_FLAG    = q.match;
  assign CHECK_PASS_FLAG     = q.pass;
  assign EVENT_PIN_ZERO      = q.done;

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RESETN);

  sequence frame_open;
    q.st == ST_IDLE && SYNC_DETECT;
  endsequence

  sequence bad_check_end;
    q.st == ST_CHK_LO && got && !chk_ok;
  endsequence

  sync_start_a: assert property (
    frame_open |=> FRAME_MATCH_FLAG && !EVENT_PIN_ZERO && q.st != ST_IDLE
  ) else $error("sync did not open a frame");

  idle_quiet_a: assert property (
    q.st == ST_IDLE && !SYNC_DETECT |=> $stable(q.wr) && !$rose(EVENT_PIN_ZERO)
  ) else $error("queue or event changed outside a frame");

  len_drop_a: assert property (
    q.st == ST_LEN && got && b > MAX_LEN_SETTING && MAX_LEN_SETTING != 8'hFF
    |=> q.st == ST_IDLE && q.cnt == 7'h00 && !FRAME_MATCH_FLAG
  ) else $error("oversized length not discarded");

  len_load_a: assert property (
    q.st == ST_LEN && got && b != 8'h00 && (b <= MAX_LEN_SETTING || MAX_LEN_SETTING == 8'hFF)
    |=> q.st == ST_BODY && q.rem == $past(b)
  ) else $error("length byte not loaded");

  own_addr_a: assert property (
    q.st == ST_BODY && q.addr_chk && got && ADDR_FILTER_SEL == 2'h1 && b != OWN_NODE_ID
    |=> q.st == ST_IDLE && !FRAME_MATCH_FLAG && q.cnt == 7'h00
  ) else $error("foreign address accepted");

  bcast_addr_a: assert property (
    q.st == ST_BODY && q.addr_chk && got && ADDR_FILTER_SEL == 2'h2
    && b == BROADCAST_NODE_ID && q.rem > 8'h01
    |=> q.st == ST_BODY && FRAME_MATCH_FLAG
  ) else $error("broadcast address refused");

  fixed_end_a: assert property (
    q.st == ST_BODY && !unlim && got && q.rem == 8'h01 && !q.addr_chk
    |=> q.st != ST_BODY
  ) else $error("payload count overran");

  fail_clear_a: assert property (
    bad_check_end ##0 !KEEP_ON_FAIL |=> q.cnt == 7'h00 && !EVENT_PIN_ZERO && !CHECK_PASS_FLAG
  ) else $error("failed check kept the payload");

  fail_keep_a: assert property (
    bad_check_end ##0 KEEP_ON_FAIL && !AES_ENABLE |=> EVENT_PIN_ZERO && !CHECK_PASS_FLAG
  ) else $error("keep-on-fail lost completion");

  crc_out_a: assert property (
    q.st == ST_CHK_HI || q.st == ST_CHK_LO |=> q.cnt <= $past(q.cnt)
  ) else $error("checksum byte entered the queue");

  aes_hold_a: assert property (
    q.st == ST_DECRYPT && q.wait_cnt != BLK_LAST |=> q.st == ST_DECRYPT && !EVENT_PIN_ZERO
  ) else $error("completion before decryption end");

endmodule : rx_packet_handler

`default_nettype wire

// ===== rx_pkt_regs.svh
// Constants for the receive packet handler: sizes, codes, check and timing counts.
// Included by the package, by the handler and by its checksum unit; the interface file does without it.
`ifndef RX_PKT_REGS_SVH
`define RX_PKT_REGS_SVH

`define QUEUE_DEPTH     66
`define LEN_FILTER_OFF  8'hFF
`define ADDR_SEL_OWN    2'h1
`define ADDR_SEL_BCAST  2'h2
`define DECODE_MANCH    2'h1
`define CHECK_POLY      16'h1021
`define CHECK_PRESET    16'h1D0F
`define CLK_MHZ         200
`define AES_BLOCK_NS    7000
`define AES_BLOCK_CYC   ((`AES_BLOCK_NS * `CLK_MHZ) / 1000)
`define AES_BLOCK_BYTES 16

`endif

// ===== rx_pkt_pkg.sv
// Types of the receive packet handler: states and the registered state records.
// Needs rx_pkt_regs.svh on the include path.
`include "rx_pkt_regs.svh"

package rx_pkt_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LEN,
    ST_BODY,
    ST_CHK_HI,
    ST_CHK_LO,
    ST_DECRYPT
  } rx_state_type;

  typedef struct packed {
    rx_state_type                        st;
    logic [`QUEUE_DEPTH-1:0][7:0]        mem;
    logic [6:0]                          wr;
    logic [6:0]                          rd;
    logic [6:0]                          cnt;
    logic [7:0]                          rem;
    logic                                addr_chk;
    logic                                half;
    logic [7:0]                          chip_hi;
    logic [7:0]                          crc_hi;
    logic [`AES_BLOCK_BYTES-1:0][7:0]    key;
    logic [6:0]                          msg_ptr;
    logic [6:0]                          msg_cnt;
    logic [10:0]                         wait_cnt;
    logic [7:0]                          dout;
    logic                                match;
    logic                                pass;
    logic                                done;
  } handler_state_type;

  typedef struct packed {
    logic [15:0] crc;
  } check_state_type;

endpackage : rx_pkt_pkg

// ===== check_if.sv
// Link between the packet handler and its checksum unit.
// Both ends run on the same clock; no timing of its own.
`timescale 1ns/100ps
`default_nettype none

interface check_if;
  logic        init;
  logic        en;
  logic [7:0]  data;
  logic [15:0] crc;

  modport host (output init, output en, output data, input crc);
  modport unit (input init, input en, input data, output crc);
endinterface : check_if

`default_nettype wire

// ===== check_unit.sv
// Byte-wide 16-bit checksum register, MSB first.
// Fed by the handler with payload bytes only; preset on each new frame.
`timescale 1ns/100ps
`default_nettype none
`include "rx_pkt_regs.svh"

module check_unit
  import rx_pkt_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  check_if.unit     ck
);

  check_state_type q;
  check_state_type d;

  always_comb begin
    logic [15:0] c;
    logic        fb;
    c  = q.crc;
    fb = 1'b0;
    d  = q;
    if (ck.init) begin
      d.crc = `CHECK_PRESET;
    end else if (ck.en) begin
      for (int i = 7; i >= 0; i--) begin
        fb = c[15] ^ ck.data[i];
        c  = {c[14:0], 1'b0};
        if (fb) begin
          c = c ^ `CHECK_POLY;
        end
      end
      d.crc = c;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign ck.crc = q.crc;

endmodule : check_unit

`default_nettype wire

// ===== rx_host_model.sv
// Host side model: pops the handler's queue and keeps every byte it gets.
// Assumes the handler's queue read contract: data valid the edge after a pop.
`timescale 1ns/100ps
`default_nettype none

module rx_host_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       en,
  input  wire logic       slow,
  input  wire logic       has_bytes,
  input  wire logic [7:0] data,
  output logic            rd
);
  logic [7:0] got[$];
  logic       rd_q;
  logic       tick;

  // Sync pattern is set upstream, never with a zero byte
  // Pops only on not-empty, also while a frame still arrives
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd   <= 1'b0;
      rd_q <= 1'b0;
      tick <= 1'b0;
    end else begin
      tick <= ~tick;
      // Gap after each pop: count settles before the next look
      rd   <= en && has_bytes && !rd && (!slow || tick);
      rd_q <= rd;
      if (rd_q) begin
        got.push_back(data);
      end
    end
  end
endmodule : rx_host_model

`default_nettype wire

// ===== rx_packet_handler_tb.sv
// Self-checking bench for the receive packet handler.
// Assumes the host model drains the queue; frames are built here.
`timescale 1ns/100ps
`default_nettype none

module rx_packet_handler_tb;
  logic       clk, rst_n, sync, vld, lfmt, chk_on, keep, aes, key_wr, host_en, slow, acc;
  logic [7:0] byt, max_len, own, bcast, key_b;
  logic [1:0] asel, dec;
  logic [3:0] key_i;
  wire logic  rd, has, lvl, match, pass, ev;
  wire logic [7:0] qdata;
  logic [7:0] pk[$], ex[$];
  logic [7:0] adr[3] = '{8'h5A, 8'hFF, 8'h33};
  int         mismatches, check_count, base, cyc;

  rx_packet_handler dut (
    .REF_CLK(clk), .RESETN(rst_n), .SYNC_DETECT(sync), .RX_BYTE_VALID(vld),
    .RX_BYTE(byt), .MAX_LEN_SETTING(max_len), .LENGTH_FORMAT_SELECT(lfmt),
    .ADDR_FILTER_SEL(asel), .OWN_NODE_ID(own), .BROADCAST_NODE_ID(bcast),
    .CHECK_ENABLE(chk_on), .KEEP_ON_FAIL(keep), .LINE_DECODE_SEL(dec),
    .AES_ENABLE(aes), .KEY_WR(key_wr), .KEY_IDX(key_i), .KEY_BYTE(key_b),
    .QUEUE_RD(rd), .QUEUE_THRESHOLD(7'h10), .QUEUE_DATA(qdata),
    .QUEUE_HAS_BYTES(has), .QUEUE_LEVEL_REACHED(lvl),
    .FRAME_MATCH_FLAG(match), .CHECK_PASS_FLAG(pass), .EVENT_PIN_ZERO(ev)
  );
  rx_host_model host (.clk(clk), .rst_n(rst_n), .en(host_en), .slow(slow),
    .has_bytes(has), .data(qdata), .rd(rd));

  task final_report;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Independent checksum: MSB first, preset and inverted result
  function automatic logic [15:0] crc_of();
    logic [15:0] c;
    c = 16'h1D0F;
    foreach (pk[i]) for (int k = 7; k >= 0; k--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ pk[i][k]) ? 16'h1021 : 16'h0000);
    return ~c;
  endfunction : crc_of

  function automatic logic [7:0] mc(input logic [3:0] n);
    return {n[3], ~n[3], n[2], ~n[2], n[1], ~n[1], n[0], ~n[0]};
  endfunction : mc

  task automatic put(input logic [7:0] b);
    @(posedge clk);
    sync <= 1'b0;
    vld  <= 1'b1;
    byt  <= (dec == 2'h1) ? mc(b[7:4]) : b;
    if (dec == 2'h1) begin
      @(posedge clk);
      byt <= mc(b[3:0]);
    end
  endtask : put

  task automatic frame(input logic bad);
    logic [15:0] c;
    c = crc_of() ^ {15'h0000, bad};
    base = host.got.size();
    @(posedge clk);
    sync <= 1'b1;
    foreach (pk[i]) begin
      put(pk[i]);
      if (i == 0) begin
        #1 chk("match", match, 1);
      end
    end
    if (chk_on) begin
      put(c[15:8]);
      put(c[7:0]);
    end
    @(posedge clk);
    vld <= 1'b0;
  endtask : frame

  task automatic expect_out(input logic ev_e, input logic ps_e);
    int n;
    @(posedge clk);
    #1 chk("event", ev, ev_e);
    chk("pass", pass, ps_e);
    chk("match end", match, 0);
    @(posedge clk);
    host_en <= 1'b1;
    n = 0;
    while (has === 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    repeat (4) @(posedge clk);
    host_en <= 1'b0;
    chk("count", 16'(host.got.size() - base), 16'(ex.size()));
    foreach (ex[i]) chk("byte", host.got[base + i], ex[i]);
  endtask : expect_out

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      $display("timeout");
      final_report();
    end
  end

  initial begin
    {rst_n, sync, vld, keep, aes, key_wr, host_en, slow, key_i, key_b, byt} = '0;
    {lfmt, chk_on, asel, dec} = 6'h34;
    {own, bcast, max_len} = 24'h5AFF10;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    pk = {8'h03, 8'h5A, 8'h11, 8'h22};
    ex = pk;
    frame(0);
    expect_out(1, 1);
    $display("test basic done");
    for (int s = 1; s <= 2; s++) for (int a = 0; a < 3; a++) begin
      asel <= s[1:0];
      pk = {8'h02, adr[a], 8'h44};
      acc = (a == 0) || (s == 2 && a == 1);
      ex = pk;
      if (!acc) ex.delete();
      frame(0);
      expect_out(acc, acc);
    end
    $display("test address done");
    asel <= 2'h0;
    max_len <= 8'h03;
    pk = {8'h04, 8'h01, 8'h02, 8'h03, 8'h04};
    ex.delete();
    frame(0);
    expect_out(0, 0);
    pk = {8'h03, 8'h01, 8'h02, 8'h03};
    ex = pk;
    frame(0);
    expect_out(1, 1);
    $display("test length done");
    pk = {8'h02, 8'h09, 8'h08};
    ex.delete();
    frame(1);
    expect_out(0, 0);
    keep <= 1'b1;
    slow <= 1'b1;
    ex = pk;
    frame(1);
    expect_out(1, 0);
    {keep, slow} <= 2'h0;
    dec <= 2'h1;
    pk = {8'h02, 8'hA5, 8'h3C};
    ex = pk;
    frame(0);
    expect_out(1, 1);
    dec <= 2'h0;
    $display("test check and decode done");
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      key_wr <= 1'b1;
      key_i <= i[3:0];
      key_b <= 8'h30 + i[7:0];
    end
    @(posedge clk);
    key_wr <= 1'b0;
    aes <= 1'b1;
    max_len <= 8'h20;
    pk = {8'h10};
    for (int i = 0; i < 16; i++) pk.push_back(i[7:0] * 8'h07);
    ex = pk;
    for (int i = 0; i < 16; i++) ex[i + 1] = pk[i + 1] ^ (8'h30 + i[7:0]);
    frame(0);
    @(posedge clk);
    #1 chk("pass early", pass, 1);
    chk("event early", ev, 0);
    chk("level high", lvl, 1);
    base = 0;
    while (ev !== 1'b1 && base < 2000) begin
      @(posedge clk);
      base++;
    end
    chk("aes delay", 16'(base >= 1396 && base <= 1402), 1);
    base = host.got.size();
    expect_out(1, 1);
    aes <= 1'b0;
    $display("test decrypt done");
    lfmt <= 1'b0;
    max_len <= 8'h02;
    asel <= 2'h1;
    pk = {8'h5A, 8'h77};
    ex = pk;
    frame(0);
    expect_out(1, 1);
    asel <= 2'h0;
    max_len <= 8'h46;
    pk.delete();
    for (int i = 0; i < 70; i++) pk.push_back(i[7:0]);
    ex = pk;
    {host_en, slow} <= 2'h3;
    frame(0);
    expect_out(1, 1);
    slow <= 1'b0;
    $display("test fixed done");
    put(8'h01);
    put(8'h02);
    @(posedge clk);
    vld <= 1'b0;
    @(posedge clk);
    #1 chk("no sync queue", has, 0);
    chk("no sync event", ev, 0);
    $display("test no sync done");
    @(posedge clk);
    lfmt <= 1'b0;
    max_len <= 8'h00;
    pk = {8'h01, 8'h02, 8'h03};
    frame(0);
    @(posedge clk);
    #1 chk("unlim event", ev, 0);
    chk("unlim match", match, 1);
    chk("unlim queue", has, 1);
    chk("level low", lvl, 0);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 chk("reset queue", has, 0);
    chk("reset match", match, 0);
    chk("reset event", ev, 0);
    $display("test unlimited done");
    final_report();
  end
endmodule : rx_packet_handler_tb

`default_nettype wire
